// >>> hdl/pcxg_regs.v
// capability header and gpio configuration registers of the bridge
// assumes the config decoder gives one-cycle read and write strobes with a byte address
// Function
// [R1] W1S/W1C fields switch gpio output enables
// [R2] W1S/W1C fields switch gpio output values
// [R3] gpio top nibble reads sampled pins; rest zero
// [R4] capability id reads 07h
// [R5] next capability pointer reads 90h
// [R6] secondary 64-bit flag reads zero
// [R7] 133 MHz, discarded, overrun flags read zero
// [R8] unexpected split completion sticky, write-one clears
// [R9] split request delayed sets sticky flag
// [R10] secondary clock code reported read-only
// [R11] function number reported read-only, resets 000
// [R12] secondary status top bits reserved zero
`include "pcxg_defs.vh"
`default_nettype none

module pcxg_regs (
    input  wire        i_clk,
    input  wire        i_nrst,
    input  wire        i_wr,
    input  wire        i_rd,
    input  wire [7:0]  i_addr,
    input  wire [3:0]  i_be,
    input  wire [31:0] i_wdata,
    output reg  [31:0] o_rdata,
    output reg         o_rvalid,
    input  wire [3:0]  i_gpio_in,
    output reg  [3:0]  o_gpio_out,
    output reg  [3:0]  o_gpio_oe,
    input  wire        i_unexp_split,
    input  wire [7:0]  i_sec_bus,
    input  wire [7:0]  i_cpl_bus,
    input  wire [4:0]  i_cpl_dev,
    input  wire [2:0]  i_cpl_func,
    input  wire        i_split_delay,
    input  wire [2:0]  i_sec_clk_code,
    input  wire [2:0]  i_func_num
);
    //--------------------------------------------------------------
    // pin sampling
    //--------------------------------------------------------------
    wire [3:0] gpio_level;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_sync
            pcxg_sync u_sync (
                .i_clk   (i_clk),
                .i_nrst  (i_nrst),
                .i_pin   (i_gpio_in[g]),
                .o_level (gpio_level[g])
            );
        end
    endgenerate

    //--------------------------------------------------------------
    // write decode
    //--------------------------------------------------------------
    wire       wr_gpio = i_wr && (i_addr == `PCXG_OFS_GPIO);
    wire       wr_cap  = i_wr && (i_addr == `PCXG_OFS_CAP);
    wire [3:0] out_clr = (wr_gpio && i_be[1]) ? i_wdata[`PCXG_GPIO_OUT_CLR_LSB +: 4] : 4'h0;
    wire [3:0] out_set = (wr_gpio && i_be[2]) ? i_wdata[`PCXG_GPIO_OUT_SET_LSB +: 4] : 4'h0;
    wire [3:0] oe_clr  = (wr_gpio && i_be[2]) ? i_wdata[`PCXG_GPIO_OE_CLR_LSB +: 4] : 4'h0;
    wire [3:0] oe_set  = (wr_gpio && i_be[3]) ? i_wdata[`PCXG_GPIO_OE_SET_LSB +: 4] : 4'h0;
    wire       clr_unexp = wr_cap && i_be[2] && i_wdata[`PCXG_BIT_UNEXP_SPLIT];

    // requester id must match secondary bus, device 0, function 0
    wire unexp_hit = i_unexp_split && (i_cpl_bus == i_sec_bus) &&
                     (i_cpl_dev == 5'h00) && (i_cpl_func == 3'h0);

    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    reg       unexp_flag;
    reg       delay_flag;
    reg [2:0] clk_code;
    reg [2:0] func_num;
    reg [3:0] next_out;
    reg [3:0] next_oe;

    // set wins over clear when both hit one bit in the same write
    always @* begin
        next_out = (o_gpio_out & ~out_clr) | out_set; // [R2]
        next_oe  = (o_gpio_oe & ~oe_clr) | oe_set;    // [R1]
    end

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_gpio_out <= `PCXG_GPIO_RST;
            o_gpio_oe  <= `PCXG_GPIO_RST;
            unexp_flag <= 1'b0;
            delay_flag <= 1'b0;
            clk_code   <= `PCXG_CLK_CONV;
            func_num   <= `PCXG_FUNC_RST;
        end else begin
            o_gpio_out <= next_out;
            o_gpio_oe  <= next_oe;
            // a new event in the clearing cycle keeps the flag set
            if (unexp_hit) begin
                unexp_flag <= 1'b1; // [R8]
            end else if (clr_unexp) begin
                unexp_flag <= 1'b0; // [R8]
            end
            // read-only: no software path clears it, only reset
            if (i_split_delay) begin
                delay_flag <= 1'b1; // [R9]
            end
            // reserved codes are reported as conventional mode
            case (i_sec_clk_code)
                `PCXG_CLK_66:  clk_code <= `PCXG_CLK_66;   // [R10]
                `PCXG_CLK_133: clk_code <= `PCXG_CLK_133;  // [R10]
                default:       clk_code <= `PCXG_CLK_CONV; // [R10]
            endcase
            func_num <= i_func_num; // [R11]
        end
    end

    //--------------------------------------------------------------
    // read mux
    //--------------------------------------------------------------
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (i_addr)
            `PCXG_OFS_GPIO: begin
                // bits 27:12 are write strobes and read back zero
                rd_mux[`PCXG_GPIO_IN_LSB +: 4] = gpio_level; // [R3]
            end
            `PCXG_OFS_CAP: begin
                rd_mux[7:0]  = `PCXG_CAP_ID;   // [R4]
                rd_mux[15:8] = `PCXG_NEXT_PTR; // [R5]
                // bits 16,17,18,20 and 31:25 stay zero
                rd_mux[`PCXG_BIT_UNEXP_SPLIT]     = unexp_flag; // [R6] [R7] [R12]
                rd_mux[`PCXG_BIT_SPLIT_DELAY]     = delay_flag; // [R9]
                rd_mux[`PCXG_CLK_FREQ_LSB +: 3]   = clk_code;   // [R10]
            end
            `PCXG_OFS_BRIDGE: begin
                rd_mux[2:0] = func_num; // [R11]
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_rdata  <= 32'h0000_0000;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd;
            if (i_rd) begin
                o_rdata <= rd_mux;
            end
        end
    end
endmodule

`default_nettype wire

// >>> hdl/pcxg_defs.vh
// register offsets, field positions and reset values of the capability and gpio bank
// assumes a 32-bit configuration access port with byte enables
`ifndef PCXG_DEFS_VH
`define PCXG_DEFS_VH

`define PCXG_OFS_RSVD_A        8'h74
`define PCXG_OFS_GPIO          8'h78
`define PCXG_OFS_RSVD_B        8'h7C
`define PCXG_OFS_CAP           8'h80
`define PCXG_OFS_BRIDGE        8'h84

`define PCXG_GPIO_OUT_CLR_LSB  12
`define PCXG_GPIO_OUT_SET_LSB  16
`define PCXG_GPIO_OE_CLR_LSB   20
`define PCXG_GPIO_OE_SET_LSB   24
`define PCXG_GPIO_IN_LSB       28

`define PCXG_CAP_ID            8'h07
`define PCXG_NEXT_PTR          8'h90
`define PCXG_BIT_UNEXP_SPLIT   19
`define PCXG_BIT_SPLIT_DELAY   21
`define PCXG_CLK_FREQ_LSB      22

`define PCXG_CLK_CONV          3'h0
`define PCXG_CLK_66            3'h1
`define PCXG_CLK_133           3'h2

`define PCXG_GPIO_RST          4'h0
`define PCXG_FUNC_RST          3'h0

`endif

// >>> hdl/pcxg_sync.v
// three-stage synchroniser for one pin input
// assumes i_pin is asynchronous to i_clk
`default_nettype none

module pcxg_sync (
    input  wire i_clk,
    input  wire i_nrst,
    input  wire i_pin,
    output reg  o_level
);
    reg s1;
    reg s2;
    reg s3;

    // s1 is read only by s2; level moves once s2 and s3 agree
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            s1      <= 1'b0;
            s2      <= 1'b0;
            s3      <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
endmodule

`default_nettype wire

// >>> verif/pcxg_pins.sv
// gpio pin model: driven pins follow the block, others the outside level
// assumes i_ext is what the board forces onto undriven pins
`default_nettype none
module pcxg_pins (
    input  wire logic [3:0] i_oe,
    input  wire logic [3:0] i_out,
    input  wire logic [3:0] i_ext,
    output logic      [3:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule
`default_nettype wire

// >>> verif/pcxg_props.sv
// port checks of the capability and gpio register bank
// assumes bound to pcxg_regs, one clock, synchronous reset
`default_nettype none
module pcxg_props (
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  i_addr,
    input wire logic [3:0]  i_be,
    input wire logic [31:0] i_wdata,
    input wire logic [31:0] o_rdata,
    input wire logic [3:0]  o_gpio_out,
    input wire logic [3:0]  o_gpio_oe,
    input wire logic [2:0]  i_sec_clk_code,
    input wire logic [2:0]  i_func_num
);
    timeunit 1ns;
    timeprecision 1ps;
    logic w78;
    assign w78 = i_wr && i_addr == 8'h78;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    oe_set_a: assert property (w78 && i_be[3] |=>
        (o_gpio_oe | ~$past(i_wdata[27:24])) == 4'hF) else $error("oe set lost");
    oe_clr_a: assert property (w78 && i_be[2] && !i_be[3] |=>
        (o_gpio_oe & $past(i_wdata[23:20])) == 4'h0) else $error("oe clear lost");
    out_set_a: assert property (w78 && i_be[2] |=>
        (o_gpio_out | ~$past(i_wdata[19:16])) == 4'hF) else $error("out set lost");
    out_clr_a: assert property (w78 && i_be[1] && !i_be[2] |=>
        (o_gpio_out & $past(i_wdata[15:12])) == 4'h0) else $error("out clear lost");
    gpio_rsvd_a: assert property (i_rd && i_addr == 8'h78 |=>
        o_rdata[27:0] == 28'h0) else $error("gpio low bits not zero");
    cap_hdr_a: assert property (i_rd && i_addr == 8'h80 |=>
        o_rdata[15:0] == 16'h9007 && o_rdata[18:16] == 3'h0 && o_rdata[20] == 1'b0
        && o_rdata[31:25] == 7'h0) else $error("capability header wrong");
    // past reset check skips the read taken while code registers still reload
    clk_code_a: assert property (i_rd && i_addr == 8'h80 && $past(i_nrst) &&
        $stable(i_sec_clk_code) |=> o_rdata[24:22] == ($past(i_sec_clk_code) > 3'h2 ?
        3'h0 : $past(i_sec_clk_code))) else $error("clock code wrong");
    func_num_a: assert property (i_rd && i_addr == 8'h84 && $past(i_nrst) &&
        $stable(i_func_num) |=> o_rdata == {29'h0, $past(i_func_num)}) else $error("func wrong");
    cover property (w78 && i_be == 4'hF);
    cover property (i_rd && i_addr == 8'h80);
    cover property (i_rd && i_addr == 8'h84);
endmodule
bind pcxg_regs pcxg_props u_props (.i_clk, .i_nrst, .i_wr, .i_rd, .i_addr, .i_be, .i_wdata,
    .o_rdata, .o_gpio_out, .o_gpio_oe, .i_sec_clk_code, .i_func_num);
`default_nettype wire

// >>> verif/pcxg_regs_bench.sv
// self-checking bench of the capability and gpio register bank
// assumes one-cycle strobes and the pin model on the gpio lines
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module pcxg_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_unexp_split = 0, i_split_delay = 0;
    logic [7:0] i_addr = 8'h00, i_sec_bus = 8'h3C, i_cpl_bus = 8'h3C;
    logic [3:0] i_be = 4'h0, i_ext = 4'h5, i_gpio_in, o_gpio_out, o_gpio_oe;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [4:0] i_cpl_dev = 5'h00;
    logic [2:0] i_cpl_func = 3'h0, i_sec_clk_code = 3'h0, i_func_num = 3'h0;
    logic o_rvalid;
    int n_errors = 0, n_compared = 0, cyc = 0;
    always #2 i_clk = ~i_clk;
    pcxg_regs i_dut (.i_clk, .i_nrst, .i_wr, .i_rd, .i_addr, .i_be, .i_wdata, .o_rdata,
        .o_rvalid, .i_gpio_in, .o_gpio_out, .o_gpio_oe, .i_unexp_split, .i_sec_bus,
        .i_cpl_bus, .i_cpl_dev, .i_cpl_func, .i_split_delay, .i_sec_clk_code, .i_func_num);
    pcxg_pins i_pins (.i_oe(o_gpio_oe), .i_out(o_gpio_out), .i_ext, .o_pin(i_gpio_in));
    always @(posedge i_clk) if (++cyc == 3000) begin
        n_errors++;
        summarize();
    end
    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge i_clk);
        {i_wr, i_addr, i_be, i_wdata} <= {1'b1, a, be, d};
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 `CHK(o_rvalid, 1'b1)
        @(posedge i_clk);
        #1 `CHK({o_rvalid, o_rdata}, {1'b0, e})
    endtask
    task automatic ev(input logic [1:0] f, input logic [4:0] dev);
        @(posedge i_clk);
        {i_unexp_split, i_split_delay, i_cpl_dev} <= {f, dev};
        @(posedge i_clk);
        {i_unexp_split, i_split_delay, i_cpl_dev} <= 7'h00;
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        rd(8'h78, 32'h0);
        rd(8'h80, 32'h0000_9007);
        rd(8'h84, 32'h0);
        rd(8'hF0, 32'h0);
        $display("test reset done");
        wr(8'h78, 4'hF, 32'h0F0A_0000);
        wr(8'h78, 4'h4, 32'h0005_0000);
        @(posedge i_clk);
        #1 `CHK({o_gpio_oe, o_gpio_out}, 8'hFF)
        wr(8'h78, 4'h2, 32'h0000_3000);
        wr(8'h78, 4'h4, 32'h0030_0000);
        wr(8'h78, 4'h0, 32'h0F00_0000);
        // pins pass a synchroniser, so readback trails by several edges
        repeat (6) @(posedge i_clk);
        #1 `CHK({o_gpio_oe, o_gpio_out}, 8'hCC)
        rd(8'h78, 32'hD000_0000);
        $display("test gpio done");
        ev(2'b10, 5'h01);
        rd(8'h80, 32'h0000_9007);
        ev(2'b11, 5'h00);
        rd(8'h80, 32'h0028_9007);
        wr(8'h80, 4'hF, 32'hFFFF_FFFF);
        for (int c = 0; c < 8; c++) begin
            i_sec_clk_code <= 3'(c);
            rd(8'h80, {7'h0, c < 3 ? 3'(c) : 3'h0, 22'h20_9007});
        end
        i_func_num <= 3'h5;
        rd(8'h84, 32'h0000_0005);
        $display("test status done");
        summarize();
    end
endmodule
`default_nettype wire
